// *** logic/slbs_top.sv ***
// Functional notes
// - blink 0.25 Hz without host link
// - with host: 1 Hz stopped, 4 Hz moving
// - 8 Hz reflashing, 10 Hz reconnecting
// - alarm: red and green steady lit
// - limit indication high while switch active
// - fault enters alarm, blocks motion
// - alarm flag readable by software
// - brake output high releases brake
// - shutdown: stop, engage brake, drop power
// - power-up: power, release brake, ready
// - delays power-to-release and release-to-ready
// - delays stop-to-engage and engage-to-off
// - brake disabled: release held always
// - no poweroff: windings stay, pauses only
// - delay change retargets brake state
// - enables apply immediately at any time
// - sticky option latches error indicators
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module slbs_top
   import slbs_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYC,
   parameter int H_0P25    = HALF_0P25,
   parameter int H_1       = HALF_1,
   parameter int H_4       = HALF_4,
   parameter int H_8       = HALF_8,
   parameter int H_10      = HALF_10
) (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // operating mode
   input  wire logic        host_link_i,
   input  wire logic        reflash_i,
   input  wire logic        usb_reconn_i,
   input  wire logic        move_req_i,
   // protection checks
   input  wire logic        fault_volt_i,
   input  wire logic        fault_curr_i,
   // limit switches
   input  wire logic        lim_left_i,
   input  wire logic        lim_right_i,
   // indicators and power
   output logic             led_red_o,
   output logic             led_green_o,
   output logic             lim_left_ind_o,
   output logic             lim_right_ind_o,
   output logic             brake_rel_o,
   output logic             winding_on_o,
   output logic             move_ok_o,
   output logic             irq_o
);
   import slbs_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [31:0]           ctrl_r;
   logic [15:0]           dly_pon_r, dly_rdy_r, dly_eng_r, dly_pof_r;
   logic                  alarm_r;
   logic                  err_v_r, err_i_r;
   logic [IRQ_W-1:0]      irq_st_r, irq_msk_r, irq_ev;
   logic                  wr_en, rd_en;
   logic [31:0]           status_w;
   slbs_seq_t             seq_r;

   assign wr_en     = psel_i & penable_i & pwrite_i;
   assign rd_en     = psel_i & penable_i & ~pwrite_i;
   assign pready_o  = 1'b1;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ctrl_r    <= CTRL_RST;
         dly_pon_r <= DLY_RST;
         dly_rdy_r <= DLY_RST;
         dly_eng_r <= DLY_RST;
         dly_pof_r <= DLY_RST;
         irq_msk_r <= '0;
      end else if (wr_en) begin
         unique case (paddr_i)
            ADDR_CTRL:    ctrl_r    <= pwdata_i & 32'h0000_0037;
            ADDR_DLY_PON: dly_pon_r <= pwdata_i[15:0];
            ADDR_DLY_RDY: dly_rdy_r <= pwdata_i[15:0];
            ADDR_DLY_ENG: dly_eng_r <= pwdata_i[15:0];
            ADDR_DLY_POF: dly_pof_r <= pwdata_i[15:0];
            ADDR_IRQ_MSK: irq_msk_r <= pwdata_i[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // alarm clear is a self-clearing command bit, not stored
   logic alarm_clr;
   assign alarm_clr = wr_en && (paddr_i == ADDR_CTRL) && pwdata_i[CTRL_ALARM_CLR];

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         prdata_o  <= '0;
         pslverr_o <= 1'b0;
      end else begin
         pslverr_o <= 1'b0;
         if (psel_i & ~penable_i) begin
            pslverr_o <= (paddr_i > ADDR_IRQ_MSK) || (paddr_i[1:0] != 2'b00);
            unique case (paddr_i)
               ADDR_CTRL:    prdata_o <= ctrl_r;
               ADDR_STATE:   prdata_o <= {29'h0, seq_r};
               ADDR_DLY_PON: prdata_o <= {16'h0, dly_pon_r};
               ADDR_DLY_RDY: prdata_o <= {16'h0, dly_rdy_r};
               ADDR_DLY_ENG: prdata_o <= {16'h0, dly_eng_r};
               ADDR_DLY_POF: prdata_o <= {16'h0, dly_pof_r};
               ADDR_STATUS:  prdata_o <= status_w;
               ADDR_IRQ_ST:  prdata_o <= {29'h0, irq_st_r};
               ADDR_IRQ_MSK: prdata_o <= {29'h0, irq_msk_r};
               default:      prdata_o <= '0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // alarm and error indicators
   // ----------------------------------------------------------------
   logic fault;
   assign fault = fault_volt_i | fault_curr_i;

   // a fault present in the clear cycle keeps the alarm: set wins
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         alarm_r <= 1'b0;
      end else if (fault) begin
         alarm_r <= 1'b1;
      end else if (alarm_clr) begin
         alarm_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         err_v_r <= 1'b0;
         err_i_r <= 1'b0;
      end else if (ctrl_r[CTRL_STICKY]) begin
         err_v_r <= fault_volt_i | (err_v_r & ~alarm_clr);
         err_i_r <= fault_curr_i | (err_i_r & ~alarm_clr);
      end else begin
         err_v_r <= fault_volt_i;
         err_i_r <= fault_curr_i;
      end
   end

   // ----------------------------------------------------------------
   // brake sequencer
   // ----------------------------------------------------------------
   logic [31:0] ms_cnt_r;
   logic        ms_tick;
   logic [15:0] el_r;
   logic        go;
   slbs_seq_t   seq_d_r;
   logic        seq_chg;

   assign go      = move_req_i & ~alarm_r;
   // the divider restarts on each state change, so no delay is cut
   // short by a millisecond tick that falls just after entry
   assign seq_chg = (seq_r != seq_d_r);
   assign ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1)) && !seq_chg;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         seq_d_r <= SEQ_OFF;
      end else begin
         seq_d_r <= seq_r;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || ms_tick || seq_chg) begin
         ms_cnt_r <= '0;
      end else begin
         ms_cnt_r <= ms_cnt_r + 32'h1;
      end
   end

   // elapsed ms in the current state; compared against live delay
   // registers so that a changed setting takes effect at once
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         seq_r <= SEQ_OFF;
         el_r  <= '0;
      end else begin
         if (ms_tick && el_r != 16'hffff) begin
            el_r <= el_r + 16'h1;
         end
         unique case (seq_r)
            SEQ_OFF: if (go) begin
               seq_r <= SEQ_PON;
               el_r  <= '0;
            end
            SEQ_PON: if (el_r >= dly_pon_r) begin
               seq_r <= SEQ_REL;
               el_r  <= '0;
            end
            SEQ_REL: if (!go) begin
               seq_r <= SEQ_STOPW;
               el_r  <= '0;
            end else if (el_r >= dly_rdy_r) begin
               seq_r <= SEQ_RUN;
            end
            SEQ_RUN: if (!go) begin
               seq_r <= SEQ_STOPW;
               el_r  <= '0;
            end
            SEQ_STOPW: if (go) begin
               seq_r <= SEQ_REL;
               el_r  <= dly_rdy_r;
            end else if (el_r >= dly_eng_r) begin
               seq_r <= SEQ_ENG;
               el_r  <= '0;
            end
            SEQ_ENG: if (go) begin
               seq_r <= SEQ_REL;
               el_r  <= '0;
            end else if (el_r < dly_eng_r && !ctrl_r[CTRL_PWROFF_EN]) begin
               seq_r <= SEQ_ENG;
            end else if (dly_eng_r > el_r + dly_eng_r) begin
               seq_r <= SEQ_STOPW;
            end else if (ctrl_r[CTRL_PWROFF_EN] && el_r >= dly_pof_r) begin
               seq_r <= SEQ_OFF;
            end
            default: seq_r <= SEQ_OFF;
         endcase
      end
   end

   // a longer engage delay after engagement releases the brake again
   // while the state stays SEQ_ENG; tracked by the time spent since stop
   logic [15:0] since_stop_r;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || seq_r == SEQ_RUN || seq_r == SEQ_OFF) begin
         since_stop_r <= '0;
      end else if (ms_tick && since_stop_r != 16'hffff) begin
         since_stop_r <= since_stop_r + 16'h1;
      end
   end

   logic brake_need;
   // engaged in SEQ_OFF and SEQ_PON, and in SEQ_ENG once the stop delay, as now set, has run out
   assign brake_need = (seq_r == SEQ_OFF) ||
                       (seq_r == SEQ_PON) ||
                       (seq_r == SEQ_ENG && since_stop_r >= dly_eng_r);

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         brake_rel_o  <= 1'b0;
         winding_on_o <= 1'b0;
         move_ok_o    <= 1'b0;
      end else begin
         brake_rel_o  <= ~ctrl_r[CTRL_BRAKE_EN] | ~brake_need;
         // an alarm stops motion through go; windings then drop after the brake
         // has engaged, or with it when a raised engage delay released it in SEQ_ENG
         winding_on_o <= (seq_r != SEQ_OFF);
         move_ok_o    <= (seq_r == SEQ_RUN) & ~alarm_r;
      end
   end

   // ----------------------------------------------------------------
   // status blink
   // ----------------------------------------------------------------
   logic [31:0] half_sel;
   logic [31:0] blink_cnt_r;
   logic        blink_r;
   always_comb begin
      if (usb_reconn_i)         half_sel = 32'(H_10);
      else if (reflash_i)       half_sel = 32'(H_8);
      else if (!host_link_i)    half_sel = 32'(H_0P25);
      else if (seq_r == SEQ_RUN) half_sel = 32'(H_4);
      else                      half_sel = 32'(H_1);
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         blink_cnt_r <= '0;
         blink_r     <= 1'b0;
      end else if (blink_cnt_r >= half_sel - 32'h1) begin
         blink_cnt_r <= '0;
         blink_r     <= ~blink_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + 32'h1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         led_red_o       <= 1'b0;
         led_green_o     <= 1'b0;
         lim_left_ind_o  <= 1'b0;
         lim_right_ind_o <= 1'b0;
      end else begin
         led_green_o     <= 1'b1;
         led_red_o       <= alarm_r | blink_r;
         lim_left_ind_o  <= lim_left_i ^ ~ctrl_r[CTRL_LIM_POL_L];
         lim_right_ind_o <= lim_right_i ^ ~ctrl_r[CTRL_LIM_POL_R];
      end
   end

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   logic alarm_d_r, ready_d_r, off_d_r;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         alarm_d_r <= 1'b0;
         ready_d_r <= 1'b0;
         off_d_r   <= 1'b1;
      end else begin
         alarm_d_r <= alarm_r;
         ready_d_r <= seq_r == SEQ_RUN;
         off_d_r   <= seq_r == SEQ_OFF;
      end
   end
   assign irq_ev = {(seq_r == SEQ_OFF) & ~off_d_r,
                    (seq_r == SEQ_RUN) & ~ready_d_r,
                    alarm_r & ~alarm_d_r};

   // a new event beats a write-one-to-clear in the same cycle
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         irq_st_r <= '0;
      end else if (wr_en && paddr_i == ADDR_IRQ_ST) begin
         irq_st_r <= (irq_st_r & ~pwdata_i[IRQ_W-1:0]) | irq_ev;
      end else begin
         irq_st_r <= irq_st_r | irq_ev;
      end
   end

   assign irq_o = |(irq_st_r & irq_msk_r);

   assign status_w = {26'h0, winding_on_o, ~brake_rel_o, move_ok_o,
                      err_i_r, err_v_r, alarm_r};
endmodule // slbs_top
`default_nettype wire

// *** logic/slbs_pkg.sv ***
package slbs_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL    = 12'h000;
   localparam logic [11:0] ADDR_STATE   = 12'h004;
   localparam logic [11:0] ADDR_DLY_PON = 12'h008;
   localparam logic [11:0] ADDR_DLY_RDY = 12'h00c;
   localparam logic [11:0] ADDR_DLY_ENG = 12'h010;
   localparam logic [11:0] ADDR_DLY_POF = 12'h014;
   localparam logic [11:0] ADDR_STATUS  = 12'h018;
   localparam logic [11:0] ADDR_IRQ_ST  = 12'h01c;
   localparam logic [11:0] ADDR_IRQ_MSK = 12'h020;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int CTRL_BRAKE_EN   = 0;
   localparam int CTRL_PWROFF_EN  = 1;
   localparam int CTRL_STICKY     = 2;
   localparam int CTRL_ALARM_CLR  = 3;
   localparam int CTRL_LIM_POL_L  = 4;
   localparam int CTRL_LIM_POL_R  = 5;
   localparam logic [31:0] CTRL_RST = 32'h0000_0003;

   // status bits
   localparam int ST_ALARM    = 0;
   localparam int ST_ERR_V    = 1;
   localparam int ST_ERR_I    = 2;
   localparam int ST_READY    = 3;
   localparam int ST_BRAKE    = 4;
   localparam int ST_WINDING  = 5;

   // interrupt events
   localparam int IRQ_ALARM  = 0;
   localparam int IRQ_READY  = 1;
   localparam int IRQ_OFF    = 2;
   localparam int IRQ_W      = 3;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ       = 100_000_000;
   localparam int MS_NS        = 1_000_000;
   localparam int CLK_NS       = 10;
   localparam int MS_CYC       = MS_NS / CLK_NS;
   localparam logic [15:0] DLY_RST = 16'h0064;
   // blink half periods in milli-hertz based cycle counts
   localparam int HZ_0P25_MHZ = 250;
   localparam int HZ_1_MHZ    = 1000;
   localparam int HZ_4_MHZ    = 4000;
   localparam int HZ_8_MHZ    = 8000;
   localparam int HZ_10_MHZ   = 10000;
   localparam int HALF_0P25 = (CLK_HZ / HZ_0P25_MHZ) * 500;
   localparam int HALF_1    = (CLK_HZ / HZ_1_MHZ) * 500;
   localparam int HALF_4    = (CLK_HZ / HZ_4_MHZ) * 500;
   localparam int HALF_8    = (CLK_HZ / HZ_8_MHZ) * 500;
   localparam int HALF_10   = (CLK_HZ / HZ_10_MHZ) * 500;

   // ----------------------------------------------------------------
   // brake sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SEQ_OFF     = 3'b000,
      SEQ_PON     = 3'b001,
      SEQ_REL     = 3'b010,
      SEQ_RUN     = 3'b011,
      SEQ_STOPW   = 3'b100,
      SEQ_ENG     = 3'b101
   } slbs_seq_t;
endpackage

// *** tb/slbs_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module slbs_sva
   import slbs_pkg::*;
(
   // clock and bus
   input wire logic        mclk_i,
   input wire logic        sys_rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic        pready_o,
   // inputs
   input wire logic        move_req_i,
   input wire logic        fault_volt_i,
   input wire logic        fault_curr_i,
   input wire logic        lim_left_i,
   input wire logic        lim_right_i,
   // outputs
   input wire logic        led_red_o,
   input wire logic        led_green_o,
   input wire logic        lim_left_ind_o,
   input wire logic        lim_right_ind_o,
   input wire logic        brake_rel_o,
   input wire logic        winding_on_o,
   input wire logic        move_ok_o
);
   // snooped control copy: right polarity, left polarity, brake enable
   logic [2:0] cfg_r;
   logic       act_l, act_r, flt;
   assign act_l = (lim_left_i == cfg_r[1]);
   assign act_r = (lim_right_i == cfg_r[2]);
   assign flt = fault_volt_i || fault_curr_i;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cfg_r <= 3'h1;
      end else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == ADDR_CTRL) begin
         cfg_r <= {pwdata_i[CTRL_LIM_POL_R], pwdata_i[CTRL_LIM_POL_L], pwdata_i[CTRL_BRAKE_EN]};
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   alarm_lit_a: assert property (flt |-> ##[1:3] (led_red_o && led_green_o))
      else $error("alarm lamp not yellow");
   fault_block_a: assert property (flt |-> ##[1:3] !move_ok_o)
      else $error("motion allowed in fault");
   ready_order_a: assert property ($rose(move_ok_o) |-> brake_rel_o && winding_on_o)
      else $error("ready before power or release");
   stop_drop_a: assert property (!move_req_i |-> ##[1:3] !move_ok_o)
      else $error("motion not stopped");
   release_wait_a: assert property ($rose(winding_on_o) && cfg_r[0] |-> !brake_rel_o [*8])
      else $error("brake released too soon");
   off_order_a: assert property ($fell(winding_on_o) && cfg_r[0] |-> $past(!brake_rel_o))
      else $error("power removed before brake");
   brake_hold_a: assert property (!cfg_r[0] [*4] |-> brake_rel_o)
      else $error("disabled brake not released");
   limit_left_a: assert property ($stable(act_l) [*3] ##0 !$past(sys_rst_i, 4) |-> lim_left_ind_o == act_l)
      else $error("left limit indication wrong");
   limit_right_a: assert property ($stable(act_r) [*3] ##0 !$past(sys_rst_i, 4) |-> lim_right_ind_o == act_r)
      else $error("right limit indication wrong");
   ready_seen_c: cover property ($rose(move_ok_o));
   power_off_c: cover property ($fell(winding_on_o));
   alarm_seen_c: cover property (flt ##1 (led_red_o && led_green_o));
endmodule // slbs_sva
bind slbs_top slbs_sva u_sva (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
   .move_req_i(move_req_i), .fault_volt_i(fault_volt_i), .fault_curr_i(fault_curr_i),
   .lim_left_i(lim_left_i), .lim_right_i(lim_right_i), .led_red_o(led_red_o),
   .led_green_o(led_green_o), .lim_left_ind_o(lim_left_ind_o),
   .lim_right_ind_o(lim_right_ind_o), .brake_rel_o(brake_rel_o),
   .winding_on_o(winding_on_o), .move_ok_o(move_ok_o)
);
`default_nettype wire

// *** tb/slbs_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module slbs_far_model (
   // clock and lamp or brake drive
   input wire logic   mclk_i,
   input wire logic   sys_rst_i,
   input wire logic   led_red_i,
   input wire logic   led_green_i,
   input wire logic   brake_rel_i,
   // observations
   output logic [15:0] half_o,
   output logic [15:0] toggles_o,
   output logic        magnet_on_o,
   output logic        yellow_o
);
   logic        red_r;
   logic [15:0] cnt_r;
   // converter powers the magnet only on a high drive, so no drive keeps the shaft clamped
   assign magnet_on_o = brake_rel_i;
   assign yellow_o = led_red_i & led_green_i;
   always_ff @(posedge mclk_i) begin
      red_r <= led_red_i;
      if (sys_rst_i) begin
         cnt_r <= 16'h0;
         half_o <= 16'h0;
         toggles_o <= 16'h0;
      end else if (led_red_i != red_r) begin
         half_o <= cnt_r;
         cnt_r <= 16'h1;
         toggles_o <= toggles_o + 16'h1;
      end else begin
         cnt_r <= cnt_r + 16'h1;
      end
   end
endmodule // slbs_far_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import slbs_pkg::*;
   // ------
   // shortened counts; every expectation follows from them
   // ------
   localparam int MS = 10;
   localparam int HQ = 40;
   localparam int H1 = 20;
   localparam int H4 = 8;
   localparam int H8 = 6;
   localparam int H10 = 4;
   logic        mclk_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
   logic        pwrite_i = 1'b0, host_link_i = 1'b0, reflash_i = 1'b0, usb_reconn_i = 1'b0;
   logic        move_req_i = 1'b0, fault_volt_i = 1'b0, fault_curr_i = 1'b0;
   logic        lim_left_i = 1'b1, lim_right_i = 1'b1;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic        pready_o, pslverr_o, err, led_red_o, led_green_o, lim_left_ind_o;
   logic        lim_right_ind_o, brake_rel_o, winding_on_o, move_ok_o, irq_o, magnet_on, yellow;
   logic [15:0] half, tgl;
   logic [2:0]  seqv;
   logic [1:0]  pol, lim;
   logic [2:0]  md [5] = '{3'b000, 3'b100, 3'b110, 3'b101, 3'b011};
   int          hx [5] = '{HQ, H1, H8, H10, H10};
   int          d [4];
   int          miscompares = 0, checks_done = 0, cyc = 0, n, t;
   assign seqv = {move_ok_o, brake_rel_o, winding_on_o};
   always #5 mclk_i = ~mclk_i;
   slbs_top #(.MS_CYCLES(MS), .H_0P25(HQ), .H_1(H1), .H_4(H4), .H_8(H8), .H_10(H10)) uut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .host_link_i(host_link_i),
      .reflash_i(reflash_i), .usb_reconn_i(usb_reconn_i), .move_req_i(move_req_i),
      .fault_volt_i(fault_volt_i), .fault_curr_i(fault_curr_i), .lim_left_i(lim_left_i),
      .lim_right_i(lim_right_i), .led_red_o(led_red_o), .led_green_o(led_green_o),
      .lim_left_ind_o(lim_left_ind_o), .lim_right_ind_o(lim_right_ind_o),
      .brake_rel_o(brake_rel_o), .winding_on_o(winding_on_o), .move_ok_o(move_ok_o),
      .irq_o(irq_o));
   slbs_far_model u_far (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .led_red_i(led_red_o),
      .led_green_i(led_green_o), .brake_rel_i(brake_rel_o), .half_o(half), .toggles_o(tgl),
      .magnet_on_o(magnet_on), .yellow_o(yellow));
   // ------
   // helpers
   // ------
   function automatic logic in_ms(input int k, input int dm);
      return k >= dm * MS && k <= (dm + 1) * MS + 3;
   endfunction
   function automatic logic [1:0] lim_exp(input logic [1:0] l, input logic [1:0] p);
      return ~(l ^ p);
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= v;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic waitb(input int b, input logic v);
      n = 0;
      while (seqv[b] !== v) begin
         @(posedge mclk_i);
         n++;
      end
   endtask
   // the first toggle after a mode change may end a partial half period
   task automatic blink(input int h);
      t = int'(tgl);
      while (int'(tgl) < t + 2) @(posedge mclk_i);
      chk(32'(half >= 16'(h) && half <= 16'(h + 1)), 32'h1);
   endtask
   task automatic close_out();
      if (miscompares == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         close_out();
      end
   end
   initial begin
      void'($urandom(32'h5c1ec391));
      repeat (5) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, CTRL_RST);
      apb(1'b0, ADDR_DLY_ENG, 32'h0);
      chk(rd, 32'(DLY_RST));
      apb(1'b0, 12'h024, 32'h0);
      chk(32'(err), 32'h1);
      for (int i = 0; i < 5; i++) begin
         {host_link_i, reflash_i, usb_reconn_i} <= md[i];
         blink(hx[i]);
      end
      {host_link_i, reflash_i, usb_reconn_i} <= 3'b100;
      for (int i = 0; i < 4; i++) begin
         d[i] = 1 + int'($urandom % 3);
         apb(1'b1, ADDR_DLY_PON + 12'(4 * i), 32'(d[i]));
         apb(1'b0, ADDR_DLY_PON + 12'(4 * i), 32'h0);
         chk(rd, 32'(d[i]));
      end
      move_req_i <= 1'b1;
      waitb(0, 1'b1);
      waitb(1, 1'b1);
      chk(32'(in_ms(n, d[0])), 32'h1);
      waitb(2, 1'b1);
      chk(32'(in_ms(n, d[1])), 32'h1);
      chk(32'({magnet_on, winding_on_o}), 32'h3);
      blink(H4);
      apb(1'b0, ADDR_IRQ_ST, 32'h0);
      chk(32'(rd[IRQ_READY]), 32'h1);
      apb(1'b1, ADDR_IRQ_MSK, 32'hf);
      @(posedge mclk_i);
      chk(32'(irq_o), 32'h1);
      apb(1'b1, ADDR_IRQ_MSK, 32'h0);
      @(posedge mclk_i);
      chk(32'(irq_o), 32'h0);
      apb(1'b1, ADDR_IRQ_MSK, 32'hf);
      apb(1'b1, ADDR_IRQ_ST, 32'hf);
      @(posedge mclk_i);
      chk(32'(irq_o), 32'h0);
      move_req_i <= 1'b0;
      waitb(1, 1'b0);
      chk(32'(in_ms(n, d[2])), 32'h1);
      waitb(0, 1'b0);
      chk(32'(in_ms(n, d[3])), 32'h1);
      for (int i = 0; i < 10; i++) begin
         pol = 2'($urandom);
         lim = 2'($urandom);
         apb(1'b1, ADDR_CTRL, {26'h0, pol, 4'h3});
         {lim_right_i, lim_left_i} <= lim;
         repeat (5) @(posedge mclk_i);
         chk(32'({lim_right_ind_o, lim_left_ind_o}), 32'(lim_exp(lim, pol)));
      end
      apb(1'b1, ADDR_CTRL, 32'h2);
      repeat (3) @(posedge mclk_i);
      chk(32'(brake_rel_o), 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h3);
      repeat (3) @(posedge mclk_i);
      chk(32'(brake_rel_o), 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h1);
      move_req_i <= 1'b1;
      waitb(2, 1'b1);
      move_req_i <= 1'b0;
      repeat ((d[2] + d[3] + 2) * MS) @(posedge mclk_i);
      chk(32'({winding_on_o, magnet_on}), 32'h2);
      apb(1'b1, ADDR_DLY_ENG, 32'd50);
      repeat (3) @(posedge mclk_i);
      chk(32'(brake_rel_o), 32'h1);
      apb(1'b1, ADDR_DLY_ENG, 32'd1);
      repeat (2 * MS + 3) @(posedge mclk_i);
      chk(32'(brake_rel_o), 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h3);
      move_req_i <= 1'b1;
      waitb(2, 1'b1);
      fault_volt_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      chk(32'({led_red_o, led_green_o, yellow, move_ok_o}), 32'he);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'({rd[ST_ERR_V], rd[ST_ALARM]}), 32'h3);
      fault_volt_i <= 1'b0;
      move_req_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'({rd[ST_ERR_V], rd[ST_ALARM]}), 32'h1);
      apb(1'b0, ADDR_IRQ_ST, 32'h0);
      chk(32'(rd[IRQ_ALARM]), 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h7);
      fault_curr_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      fault_curr_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(rd[ST_ERR_I]), 32'h1);
      apb(1'b1, ADDR_CTRL, 32'hb);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(rd[ST_ALARM]), 32'h0);
      close_out();
   end
endmodule // tb_top
`default_nettype wire
